//--- logic/erc_pkg.sv
// Constants, register map and mode codes of the auxiliary regulator control block.
// Assumes a 10 MHz system clock and an AXI4-Lite master with 32-bit data.
//
// Summary of operation
// - Stand-alone: select bit 0 gives 5.0V, 1 gives 3.3V.
// - Enable written in normal mode picks stand-alone.
// - Writing load-share bit picks load-sharing configuration.
// - First choice locks; survives soft reset, not power.
// - Stand-alone lock: on/off allowed, changes silently refused.
// - Load-share lock: changes refused, failure flag set.
// - Stop mode drops load sharing unless stop-keep set.
// - Regulator state follows chip mode table.
// - Stand-alone overcurrent limits and sets flag, clearable after.
// - Stand-alone undervoltage sets the undervoltage status flag.
// - Load sharing never sets overcurrent or undervoltage flags.
// - Battery undervoltage turns regulator off unless keep-on.
// - Load sharing shuts down in fail-safe mode.
// - Stop mode adds high-power stage by base current.
// - Status is readable in the supply status register.
package erc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ERC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] ERC_HWCTRL_ADDR = 8'h04;
    localparam logic [7:0] ERC_STAT_ADDR = 8'h08;

    // ==========================================================
    // Control register fields
    localparam int ERC_CTRL_ENABLE_BIT = 0;
    localparam int ERC_CTRL_VSEL_BIT = 1;
    localparam int ERC_CTRL_KEEPON_BIT = 2;
    // Hardware control register fields
    localparam int ERC_HW_LS_BIT = 0;
    localparam int ERC_HW_STPKEEP_BIT = 1;
    // Status register fields
    localparam int ERC_ST_OC_BIT = 0;
    localparam int ERC_ST_UV_BIT = 1;
    localparam int ERC_ST_SPIFAIL_BIT = 2;
    localparam int ERC_ST_ON_BIT = 3;
    localparam int ERC_ST_CFG_LSB = 4;
    localparam int ERC_ST_VOUT_BIT = 6;
    localparam int ERC_ST_HP_BIT = 7;

    // ==========================================================
    // Reset values and bus response codes
    localparam logic [31:0] ERC_ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0] ERC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ERC_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Chip operating modes, as delivered by the mode controller
    typedef enum logic [2:0] {
        ERC_MODE_INIT = 3'b000,
        ERC_MODE_NORMAL = 3'b001,
        ERC_MODE_STOP = 3'b010,
        ERC_MODE_SLEEP = 3'b011,
        ERC_MODE_RESTART = 3'b100,
        ERC_MODE_FAILSAFE = 3'b101
    } erc_mode_t;

    // Locked configuration
    typedef enum logic [1:0] {
        ERC_CFG_NONE = 2'b00,
        ERC_CFG_STANDALONE = 2'b01,
        ERC_CFG_LOADSHARE = 2'b10
    } erc_cfg_t;

endpackage : erc_pkg

//--- logic/erc_sync2.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs are slow analog comparator levels.
`timescale 1ns/100ps
`default_nettype none
module erc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : erc_sync2
`default_nettype wire

//--- logic/erc_ctrl.sv
// Control logic of the auxiliary external-transistor regulator.
// Assumes chip mode comes from logic on the same clock; analog flags are
// pin-level and are synchronised here. por_n is the power-on indication
// (low while power is lost); sys_rst is the soft reset.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module erc_ctrl
    import erc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic por_n,
    input wire erc_pkg::erc_mode_t chip_mode,
    input wire logic shunt_limit_async,
    input wire logic aux_uv_async,
    input wire logic battery_uv_async,
    input wire logic base_rise_async,
    input wire logic base_fall_async,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic aux_regulator_on,
    output logic aux_vout_3v3,
    output logic current_limit_on,
    output logic high_power_on
);
    import erc_pkg::*;

    // ==========================================================
    // Synchronisers
    logic [4:0] ana_sync;
    logic shunt_limit;
    logic aux_uv;
    logic battery_uv;
    logic base_rise;
    logic base_fall;

    erc_sync2 #(.WIDTH(5)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({base_fall_async, base_rise_async, battery_uv_async,
                   aux_uv_async, shunt_limit_async}),
        .sync_out(ana_sync)
    );
    assign shunt_limit = ana_sync[0];
    assign aux_uv = ana_sync[1];
    assign battery_uv = ana_sync[2];
    assign base_rise = ana_sync[3];
    assign base_fall = ana_sync[4];

    // ==========================================================
    // AXI4-Lite write path
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic wr_ok;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_ok = (awaddr_reg == ERC_CTRL_ADDR) || (awaddr_reg == ERC_HWCTRL_ADDR)
                   || (awaddr_reg == ERC_STAT_ADDR);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= ERC_ZERO_WORD;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr[7:0];
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ERC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? ERC_RESP_OKAY : ERC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_ctrl;
    logic wr_hw;
    logic wr_stat;
    assign wr_ctrl = wr_fire && (awaddr_reg == ERC_CTRL_ADDR) && wstrb_reg[0];
    assign wr_hw = wr_fire && (awaddr_reg == ERC_HWCTRL_ADDR) && wstrb_reg[0];
    assign wr_stat = wr_fire && (awaddr_reg == ERC_STAT_ADDR) && wstrb_reg[0];

    // ==========================================================
    // Configuration lock, held across soft reset
    // Only power loss clears it, so this register ignores sys_rst.
    erc_cfg_t cfg_reg;
    logic por_meta_reg;
    logic por_ok_reg;

    always_ff @(posedge clock) begin
        por_meta_reg <= por_n;
        por_ok_reg <= por_meta_reg;
    end

    logic want_sa;
    logic want_ls;
    assign want_sa = wr_ctrl && wdata_reg[ERC_CTRL_ENABLE_BIT]
                     && (chip_mode == ERC_MODE_NORMAL);
    assign want_ls = wr_hw && wdata_reg[ERC_HW_LS_BIT];

    always_ff @(posedge clock) begin
        if (!por_ok_reg) begin
            cfg_reg <= ERC_CFG_NONE;
        end else if (cfg_reg == ERC_CFG_NONE) begin
            if (want_ls) begin
                cfg_reg <= ERC_CFG_LOADSHARE;
            end else if (want_sa) begin
                cfg_reg <= ERC_CFG_STANDALONE;
            end
        end
    end

    // ==========================================================
    // Software control bits
    logic enable_reg;
    logic vsel_reg;
    logic keepon_reg;
    logic stop_keep_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            enable_reg <= 1'b0;
            vsel_reg <= 1'b0;
            keepon_reg <= 1'b0;
        end else if (wr_ctrl) begin
            // Voltage choice freezes once either configuration is locked
            if (cfg_reg == ERC_CFG_NONE) begin
                vsel_reg <= wdata_reg[ERC_CTRL_VSEL_BIT];
            end
            if (cfg_reg != ERC_CFG_LOADSHARE) begin
                enable_reg <= wdata_reg[ERC_CTRL_ENABLE_BIT];
            end
            keepon_reg <= wdata_reg[ERC_CTRL_KEEPON_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stop_keep_reg <= 1'b0;
        end else if (wr_hw) begin
            stop_keep_reg <= wdata_reg[ERC_HW_STPKEEP_BIT];
        end
    end

    // Attempt to clear load sharing, set enable or change the voltage once load sharing is locked
    logic ls_violation;
    assign ls_violation = (cfg_reg == ERC_CFG_LOADSHARE)
        && ((wr_hw && !wdata_reg[ERC_HW_LS_BIT])
            || (wr_ctrl && (wdata_reg[ERC_CTRL_ENABLE_BIT]
                            || wdata_reg[ERC_CTRL_VSEL_BIT] != vsel_reg)));

    // ==========================================================
    // Regulator state by chip mode
    logic sa_mode_on;
    logic ls_mode_on;
    logic supply_ok;
    logic reg_on;

    always_comb begin
        sa_mode_on = 1'b0;
        ls_mode_on = 1'b0;
        unique case (chip_mode)
            ERC_MODE_INIT: begin
                sa_mode_on = 1'b0;
                ls_mode_on = 1'b0;
            end
            ERC_MODE_NORMAL: begin
                sa_mode_on = enable_reg;
                ls_mode_on = 1'b1;
            end
            ERC_MODE_STOP: begin
                sa_mode_on = enable_reg;
                ls_mode_on = stop_keep_reg;
            end
            ERC_MODE_SLEEP: begin
                sa_mode_on = enable_reg;
                ls_mode_on = 1'b0;
            end
            ERC_MODE_RESTART: begin
                sa_mode_on = enable_reg;
                ls_mode_on = 1'b1;
            end
            ERC_MODE_FAILSAFE: begin
                sa_mode_on = 1'b0;
                ls_mode_on = 1'b0;
            end
            default: begin
                sa_mode_on = 1'b0;
                ls_mode_on = 1'b0;
            end
        endcase
    end

    assign supply_ok = !battery_uv || keepon_reg;
    assign reg_on = supply_ok
        && (((cfg_reg == ERC_CFG_STANDALONE) && sa_mode_on)
            || ((cfg_reg == ERC_CFG_LOADSHARE) && ls_mode_on));

    // ==========================================================
    // Outputs to the analog stage
    logic hp_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aux_regulator_on <= 1'b0;
            aux_vout_3v3 <= 1'b0;
            current_limit_on <= 1'b0;
        end else begin
            aux_regulator_on <= reg_on;
            // Load sharing always follows the main regulator voltage
            aux_vout_3v3 <= (cfg_reg == ERC_CFG_STANDALONE) && vsel_reg;
            current_limit_on <= (cfg_reg == ERC_CFG_STANDALONE) && reg_on;
        end
    end

    // Hysteresis between the two comparators keeps the stage from chattering
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hp_reg <= 1'b1;
        end else if (chip_mode != ERC_MODE_STOP) begin
            hp_reg <= 1'b1;
        end else if (base_rise) begin
            hp_reg <= 1'b1;
        end else if (!base_fall) begin
            hp_reg <= 1'b0;
        end
    end

    assign high_power_on = hp_reg && aux_regulator_on;

    // ==========================================================
    // Status flags; a new event wins over a software clear
    logic oc_reg;
    logic uv_reg;
    logic fail_reg;
    logic oc_set;
    logic uv_set;

    assign oc_set = (cfg_reg == ERC_CFG_STANDALONE) && aux_regulator_on
                    && shunt_limit;
    assign uv_set = (cfg_reg == ERC_CFG_STANDALONE) && aux_regulator_on
                    && aux_uv;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            oc_reg <= 1'b0;
            uv_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else begin
            if (oc_set) begin
                oc_reg <= 1'b1;
            end else if (wr_stat && wdata_reg[ERC_ST_OC_BIT]) begin
                oc_reg <= 1'b0;
            end
            if (uv_set) begin
                uv_reg <= 1'b1;
            end else if (wr_stat && wdata_reg[ERC_ST_UV_BIT]) begin
                uv_reg <= 1'b0;
            end
            if (ls_violation) begin
                fail_reg <= 1'b1;
            end else if (wr_stat && wdata_reg[ERC_ST_SPIFAIL_BIT]) begin
                fail_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read path
    logic [31:0] rd_word;
    logic [7:0] rd_addr;

    assign rd_addr = s_axi_araddr[7:0];
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_word = ERC_ZERO_WORD;
        if (rd_addr == ERC_CTRL_ADDR) begin
            rd_word[ERC_CTRL_ENABLE_BIT] = enable_reg;
            rd_word[ERC_CTRL_VSEL_BIT] = vsel_reg;
            rd_word[ERC_CTRL_KEEPON_BIT] = keepon_reg;
        end else if (rd_addr == ERC_HWCTRL_ADDR) begin
            rd_word[ERC_HW_LS_BIT] = (cfg_reg == ERC_CFG_LOADSHARE);
            rd_word[ERC_HW_STPKEEP_BIT] = stop_keep_reg;
        end else if (rd_addr == ERC_STAT_ADDR) begin
            rd_word[ERC_ST_OC_BIT] = oc_reg;
            rd_word[ERC_ST_UV_BIT] = uv_reg;
            rd_word[ERC_ST_SPIFAIL_BIT] = fail_reg;
            rd_word[ERC_ST_ON_BIT] = aux_regulator_on;
            rd_word[ERC_ST_CFG_LSB +: 2] = cfg_reg;
            rd_word[ERC_ST_VOUT_BIT] = aux_vout_3v3;
            rd_word[ERC_ST_HP_BIT] = high_power_on;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ERC_ZERO_WORD;
            s_axi_rresp <= ERC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= ((rd_addr == ERC_CTRL_ADDR) || (rd_addr == ERC_HWCTRL_ADDR)
                            || (rd_addr == ERC_STAT_ADDR)) ? ERC_RESP_OKAY : ERC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : erc_ctrl
`default_nettype wire

//--- tb/erc_pnp_model.sv
// External pass transistor and shunt seen from the control block.
// Assumes the bench sets the load, output fault and base current levels.
`timescale 1ns/100ps
`default_nettype none
module erc_pnp_model (
    input wire logic aux_regulator_on,
    input wire logic heavy_load,
    input wire logic out_short,
    input wire logic [1:0] base_level,
    output logic shunt_limit_async,
    output logic aux_uv_async,
    output logic base_rise_async,
    output logic base_fall_async
);
    // ==========================================
    // Analog levels
    // A switched-off transistor draws no base current and drops nothing
    assign shunt_limit_async = aux_regulator_on & heavy_load;
    assign aux_uv_async = aux_regulator_on & out_short;
    // Level 1 sits between the thresholds, so it exercises the hysteresis
    assign base_rise_async = aux_regulator_on & (base_level > 2'h1);
    assign base_fall_async = aux_regulator_on & (base_level != 2'h0);
endmodule : erc_pnp_model
`default_nettype wire

//--- tb/erc_ctrl_properties.sv
// Port-level properties of the auxiliary regulator control block.
// Assumes one clock domain and the synchronous soft reset.
`timescale 1ns/100ps
`default_nettype none
module erc_ctrl_properties
    import erc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire erc_pkg::erc_mode_t chip_mode,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic aux_regulator_on,
    input wire logic high_power_on
);
    // ==========================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_init_off: assert property (chip_mode == ERC_MODE_INIT |=> !aux_regulator_on)
        else $error("regulator on in init mode");
    chk_failsafe_off: assert property (
        chip_mode == ERC_MODE_FAILSAFE |=> !aux_regulator_on)
        else $error("regulator on in fail-safe mode");
    chk_hp_needs_on: assert property (high_power_on |-> aux_regulator_on)
        else $error("high power stage without regulator");
    chk_hp_in_normal: assert property (
        chip_mode == ERC_MODE_NORMAL [*2] |-> high_power_on == aux_regulator_on)
        else $error("high power stage wrong in normal mode");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during read answer");
    chk_b_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_unmapped_err: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h0C
        |=> s_axi_rresp == ERC_RESP_SLVERR && s_axi_rdata == ERC_ZERO_WORD)
        else $error("unmapped read not refused");
endmodule : erc_ctrl_properties

bind erc_ctrl erc_ctrl_properties i_chk (.clock, .sys_rst, .chip_mode, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .aux_regulator_on,
    .high_power_on);
`default_nettype wire

//--- tb/tb_ext_regulator_config_control.sv
// Self-checking bench for the auxiliary regulator control block.
// Assumes the transistor model on the far side and an AXI4-Lite master here.
`timescale 1ns/100ps
`default_nettype none
module tb_ext_regulator_config_control;
    import erc_pkg::*;
    // ==========================================
    // Wiring
    localparam logic [7:0] CT = ERC_CTRL_ADDR;
    localparam logic [7:0] HW = ERC_HWCTRL_ADDR;
    localparam logic [7:0] SA = ERC_STAT_ADDR;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic por_n = 1'b0;
    erc_mode_t chip_mode = ERC_MODE_INIT;
    logic battery_uv_async = 1'b0;
    logic heavy = 1'b0;
    logic short_out = 1'b0;
    logic [1:0] base = 2'h0;
    logic shunt_limit_async, aux_uv_async, base_rise_async, base_fall_async;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic [1:0] rsp;
    logic aux_regulator_on, aux_vout_3v3, current_limit_on, high_power_on;
    int errors = 0;
    int cmp_count = 0;
    always #50 clock = ~clock;
    erc_ctrl i_dut (.clock, .sys_rst, .por_n, .chip_mode, .shunt_limit_async, .aux_uv_async,
        .battery_uv_async, .base_rise_async, .base_fall_async, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aux_regulator_on,
        .aux_vout_3v3, .current_limit_on, .high_power_on);
    erc_pnp_model i_pnp (.aux_regulator_on, .heavy_load(heavy), .out_short(short_out),
        .base_level(base), .shunt_limit_async, .aux_uv_async, .base_rise_async,
        .base_fall_async);
    // ==========================================
    // Bus tasks and comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= {24'h00_0000, a};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, (a > SA) ? ERC_RESP_SLVERR : ERC_RESP_OKAY});
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [1:0] r);
        s_axi_araddr <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask : rd
    task automatic st(input logic [7:0] a, input logic [31:0] e);
        logic [1:0] r;
        rd(a, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, (a > SA) ? ERC_RESP_SLVERR : ERC_RESP_OKAY});
    endtask : st
    // Analog inputs pass a synchroniser, so give them time to land
    task automatic settle;
        repeat (5) @(posedge clock);
    endtask : settle
    task automatic pv(input logic [3:0] e);
        settle();
        #1;
        chk({28'h0, aux_regulator_on, aux_vout_3v3, current_limit_on, high_power_on}, {28'h0, e});
        @(posedge clock);
    endtask : pv
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // ==========================================
    // Tests
    initial begin
        #500_000;
        errors++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        por_n <= 1'b1;
        st(CT, 32'h0);
        st(SA, 32'h0);
        st(8'h0C, 32'h0);
        wr(8'h0C, 32'h0);
        s_axi_wstrb <= 4'h0;
        wr(CT, 32'h3);
        s_axi_wstrb <= 4'hF;
        st(CT, 32'h0);
        wr(CT, 32'h3);
        pv(4'h0);
        st(SA, 32'h0);
        wr(CT, 32'h2);
        chip_mode <= ERC_MODE_NORMAL;
        pv(4'h0);
        $display("test init done");
        wr(CT, 32'h3);
        pv(4'hF);
        st(SA, 32'hD8);
        wr(HW, 32'h1);
        wr(CT, 32'h1);
        pv(4'hF);
        st(SA, 32'hD8);
        wr(CT, 32'h0);
        pv(4'h4);
        wr(CT, 32'h1);
        pv(4'hF);
        heavy <= 1'b1;
        settle();
        st(SA, 32'hD9);
        wr(SA, 32'h1);
        st(SA, 32'hD9);
        heavy <= 1'b0;
        settle();
        wr(SA, 32'h1);
        st(SA, 32'hD8);
        short_out <= 1'b1;
        settle();
        short_out <= 1'b0;
        settle();
        st(SA, 32'hDA);
        wr(SA, 32'h2);
        battery_uv_async <= 1'b1;
        pv(4'h4);
        battery_uv_async <= 1'b0;
        pv(4'hF);
        wr(CT, 32'h5);
        battery_uv_async <= 1'b1;
        pv(4'hF);
        battery_uv_async <= 1'b0;
        $display("test standalone done");
        chip_mode <= ERC_MODE_STOP;
        pv(4'hE);
        base <= 2'h2;
        pv(4'hF);
        base <= 2'h1;
        pv(4'hF);
        base <= 2'h0;
        pv(4'hE);
        chip_mode <= ERC_MODE_SLEEP;
        pv(4'hF);
        chip_mode <= ERC_MODE_FAILSAFE;
        pv(4'h4);
        chip_mode <= ERC_MODE_NORMAL;
        sys_rst <= 1'b1;
        settle();
        sys_rst <= 1'b0;
        wr(HW, 32'h1);
        st(8'h0C, 32'h0);
        chk(d, 32'h0);
        rd(SA, rsp);
        chk({30'h0, rsp}, {30'h0, ERC_RESP_OKAY});
        chk(d & 32'h34, 32'h10);
        $display("test soft reset done");
        por_n <= 1'b0;
        sys_rst <= 1'b1;
        chip_mode <= ERC_MODE_INIT;
        settle();
        por_n <= 1'b1;
        sys_rst <= 1'b0;
        chip_mode <= ERC_MODE_NORMAL;
        wr(CT, 32'h2);
        wr(HW, 32'h1);
        pv(4'h9);
        st(SA, 32'hA8);
        wr(CT, 32'h3);
        st(SA, 32'hAC);
        wr(SA, 32'h4);
        wr(HW, 32'h0);
        pv(4'h9);
        st(SA, 32'hAC);
        wr(SA, 32'h4);
        heavy <= 1'b1;
        short_out <= 1'b1;
        pv(4'h9);
        st(SA, 32'hA8);
        heavy <= 1'b0;
        short_out <= 1'b0;
        battery_uv_async <= 1'b1;
        pv(4'h0);
        battery_uv_async <= 1'b0;
        pv(4'h9);
        chip_mode <= ERC_MODE_STOP;
        pv(4'h0);
        st(HW, 32'h1);
        chip_mode <= ERC_MODE_NORMAL;
        pv(4'h9);
        wr(HW, 32'h3);
        chip_mode <= ERC_MODE_STOP;
        pv(4'h8);
        chip_mode <= ERC_MODE_SLEEP;
        pv(4'h0);
        chip_mode <= ERC_MODE_RESTART;
        pv(4'h9);
        chip_mode <= ERC_MODE_FAILSAFE;
        pv(4'h0);
        $display("test load sharing done");
        conclude();
    end
endmodule : tb_ext_regulator_config_control
`default_nettype wire
